// >>> shared/relay_timer_pkg.sv
// Function
// - Short trigger still gives full-length pulse
// - Pulse ends at setpoint despite held trigger
// - Hold input freezes pulse elapsed time
// - Clear input zeroes time, contact off
// - Trigger still high after clear restarts pulse
// - Flashing offers symmetric and asymmetric ratio
// - First setpoint mark, second setpoint space
// - Symmetric equal phases, asymmetric set independently
// - Flash while trigger high, stop when low
// - Hold input freezes flash phase timer
// - Clear input resets flash timer, contact off
// - Retentive time survives power loss, stop
// - Started timer runs while section skipped
// - Steps 10 ms, 1 s, 1 min
// - Oversized setpoint saturates at range maximum
// - Fixed retentive subset, count is configuration
package relay_timer_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BASE_STEP_MS = 10;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned BASE_STEP_CYCLES = CLK_HZ / MS_PER_S * BASE_STEP_MS;
  localparam int unsigned STEPS_PER_SEC = 100;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int TW = 16;
  localparam logic [TW-1:0] SP_MAX_SEC = 16'h270F;
  localparam logic [TW-1:0] SP_MAX_CLOCK = 16'h176F;
  localparam int RET_SLOTS = 6;
  localparam int unsigned RET_SLOT [RET_SLOTS] = '{7, 8, 13, 14, 15, 16};
  localparam logic [2:0] NO_RANK = 3'h0;
  localparam logic [1:0] RESTORE_WAIT = 2'h2;
  localparam logic [1:0] RESTORE_LOAD = 2'h1;
  localparam logic [1:0] RESTORE_DONE = 2'h0;

  typedef enum logic [1:0] {
    MODE_PULSE = 2'h0,
    MODE_FLASH_SYM = 2'h1,
    MODE_FLASH_ASYM = 2'h2
  } relay_mode_t;

  typedef enum logic [1:0] {
    BASE_SEC = 2'h0,
    BASE_MIN_SEC = 2'h1,
    BASE_HR_MIN = 2'h2
  } time_base_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PULSE = 3'h1,
    ST_DONE = 3'h3,
    ST_MARK = 3'h2,
    ST_SPACE = 3'h6
  } relay_state_t;

  typedef struct packed {
    logic valid;
    relay_state_t state;
    logic [TW-1:0] elapsed;
  } retain_word_t;

  function automatic logic [TW-1:0] clamp_setpoint(input logic [TW-1:0] sp, input time_base_t base);
    logic [TW-1:0] lim;
    lim = (base == BASE_SEC) ? SP_MAX_SEC : SP_MAX_CLOCK;
    return (sp > lim) ? lim : sp;
  endfunction

  function automatic logic [2:0] retain_rank(input int unsigned inst);
    logic [2:0] r;
    r = NO_RANK;
    for (int i = 0; i < RET_SLOTS; i++) begin
      if (RET_SLOT[i] == inst) begin
        r = 3'(i + 1);
      end
    end
    return r;
  endfunction
endpackage

// >>> shared/time_tick_if.sv
`timescale 1ns/1ps
interface time_tick_if;
  logic step;
  logic sec;
  logic min;
  modport src (output step, output sec, output min);
  modport dst (input step, input sec, input min);
endinterface

// >>> hdl/time_step_gen.sv
`timescale 1ns/1ps
module time_step_gen import relay_timer_pkg::*; #(
  parameter int unsigned STEP_CYCLES = BASE_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  time_tick_if.src tk
);
  localparam int CW = $clog2(STEP_CYCLES + 1);
  logic [CW-1:0] cyc, next_cyc;
  logic [6:0] steps, next_steps;
  logic [5:0] secs, next_secs;
  logic step_now, sec_now, min_now;

  // Free running: a timing start may fall anywhere inside the first step
  always_comb begin
    step_now = (cyc == CW'(STEP_CYCLES - 1));
    sec_now = step_now && (steps == 7'(STEPS_PER_SEC - 1));
    min_now = sec_now && (secs == 6'(SEC_PER_MIN - 1));
    next_cyc = step_now ? '0 : cyc + 1'b1;
    next_steps = steps;
    next_secs = secs;
    if (step_now) begin
      next_steps = sec_now ? '0 : steps + 1'b1;
    end
    if (sec_now) begin
      next_secs = min_now ? '0 : secs + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc <= '0;
      steps <= '0;
      secs <= '0;
      tk.step <= 1'b0;
      tk.sec <= 1'b0;
      tk.min <= 1'b0;
    end else begin
      cyc <= next_cyc;
      steps <= next_steps;
      secs <= next_secs;
      tk.step <= step_now;
      tk.sec <= sec_now;
      tk.min <= min_now;
    end
  end

  chk_tick_nesting: assert property (@(posedge clk) disable iff (!arst_n)
    (tk.min |-> tk.sec && tk.step) and (tk.sec |-> tk.step))
    else $error("minute or second tick without finer tick");
endmodule // time_step_gen

// >>> hdl/retain_store.sv
`timescale 1ns/1ps
module retain_store #(
  parameter int W = 20,
  parameter int DEPTH = 6
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] rd_data
);
  // No reset on purpose: contents model the backed-up store across power loss
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule // retain_store

// >>> hdl/pulse_flash_timing_relay.sv
`timescale 1ns/1ps
module pulse_flash_timing_relay import relay_timer_pkg::*; #(
  parameter int unsigned INSTANCE_NUM = 7,
  parameter int unsigned STEP_CYCLES = BASE_STEP_CYCLES
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic RUN_MODE,
  input wire logic SECTION_SKIPPED,
  input wire logic TRIGGER_COIL_INPUT,
  input wire logic HOLD_COIL_INPUT,
  input wire logic CLEAR_COIL_INPUT,
  input wire logic [1:0] RELAY_MODE,
  input wire logic [1:0] TIME_BASE,
  input wire logic [TW-1:0] FIRST_TIME_SETPOINT,
  input wire logic [TW-1:0] SECOND_TIME_SETPOINT,
  input wire logic [2:0] RETAIN_COUNT,
  output logic SWITCH_CONTACT,
  output logic [TW-1:0] ELAPSED_TIME,
  output logic [TW-1:0] ON_PHASE_TIME,
  output logic [TW-1:0] OFF_PHASE_TIME,
  output logic RETENTIVE_ACTIVE
);
  localparam logic [2:0] RANK = retain_rank(INSTANCE_NUM);
  localparam logic [2:0] SLOT = (RANK == NO_RANK) ? NO_RANK : RANK - 3'h1;

  time_tick_if tk();

  time_step_gen #(.STEP_CYCLES(STEP_CYCLES)) u_step (
    .clk(CLK),
    .arst_n(ARST_N),
    .tk(tk)
  );

  retain_word_t saved;
  retain_word_t wr_word;
  logic wr_en;

  retain_store #(.W($bits(retain_word_t)), .DEPTH(RET_SLOTS)) u_store (
    .clk(CLK),
    .wr_en(wr_en),
    .addr(SLOT),
    .wr_data(wr_word),
    .rd_data(saved)
  );

  // Coil group: a skipped section keeps the last evaluated coil states
  logic trig, hold, clr;
  logic trig_keep, hold_keep, clr_keep;

  always_comb begin
    trig = SECTION_SKIPPED ? trig_keep : TRIGGER_COIL_INPUT;
    hold = SECTION_SKIPPED ? hold_keep : HOLD_COIL_INPUT;
    clr = SECTION_SKIPPED ? clr_keep : CLEAR_COIL_INPUT;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trig_keep <= 1'b0;
      hold_keep <= 1'b0;
      clr_keep <= 1'b0;
    end else begin
      trig_keep <= trig;
      hold_keep <= hold;
      clr_keep <= clr;
    end
  end

  // Setpoint group
  relay_mode_t mode;
  time_base_t base;
  logic is_flash;
  logic [TW-1:0] sp_on, sp_off;
  logic ret_now;
  logic tick;

  always_comb begin
    mode = relay_mode_t'(RELAY_MODE);
    base = time_base_t'(TIME_BASE);
    is_flash = (mode == MODE_FLASH_SYM) || (mode == MODE_FLASH_ASYM);
    sp_on = clamp_setpoint(FIRST_TIME_SETPOINT, base);
    // Symmetric flashing reuses the mark time so both phases match exactly
    sp_off = (mode == MODE_FLASH_SYM) ? sp_on : clamp_setpoint(SECOND_TIME_SETPOINT, base);
    ret_now = (RANK != NO_RANK) && (RANK <= RETAIN_COUNT);
    unique case (base)
      BASE_SEC: tick = tk.step;
      BASE_MIN_SEC: tick = tk.sec;
      default: tick = tk.min;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ON_PHASE_TIME <= '0;
      OFF_PHASE_TIME <= '0;
      RETENTIVE_ACTIVE <= 1'b0;
    end else begin
      ON_PHASE_TIME <= sp_on;
      OFF_PHASE_TIME <= sp_off;
      RETENTIVE_ACTIVE <= ret_now;
    end
  end

  // Timing group
  relay_state_t state, next_state;
  logic [TW-1:0] next_elapsed;
  logic next_contact;
  logic [1:0] restore_cnt, next_restore;
  logic [TW-1:0] cur_sp;
  logic expired, count_en, live;
  logic [TW-1:0] bumped;

  always_comb begin
    cur_sp = (state == ST_SPACE) ? sp_off : sp_on;
    expired = ELAPSED_TIME >= cur_sp;
    count_en = tick && !hold;
    bumped = count_en ? ELAPSED_TIME + 16'h0001 : ELAPSED_TIME;
    live = (restore_cnt == RESTORE_DONE) && !clr && RUN_MODE;
    next_state = state;
    next_elapsed = ELAPSED_TIME;
    next_contact = SWITCH_CONTACT;
    next_restore = restore_cnt;
    if (restore_cnt != RESTORE_DONE) begin
      // Memory read data needs one edge after reset before it is valid
      next_restore = restore_cnt - 2'h1;
      if (restore_cnt == RESTORE_LOAD && RETENTIVE_ACTIVE && saved.valid) begin
        next_state = saved.state;
        next_elapsed = saved.elapsed;
        next_contact = (saved.state == ST_PULSE) || (saved.state == ST_MARK);
      end
    end else if (clr) begin
      next_state = ST_IDLE;
      next_elapsed = '0;
      next_contact = 1'b0;
    end else if (!RUN_MODE) begin
      next_contact = 1'b0;
      if (!RETENTIVE_ACTIVE) begin
        next_state = ST_IDLE;
        next_elapsed = '0;
      end
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_elapsed = '0;
          // Level start: a trigger held across a clear release restarts here
          if (trig) begin
            next_state = is_flash ? ST_MARK : ST_PULSE;
            next_contact = 1'b1;
          end
        end
        ST_PULSE: begin
          // Trigger level ignored: a short trigger is lengthened
          next_contact = 1'b1;
          if (expired) begin
            next_state = ST_DONE;
            next_contact = 1'b0;
          end else begin
            next_elapsed = bumped;
          end
        end
        ST_DONE: begin
          next_contact = 1'b0;
          if (!trig) begin
            next_state = ST_IDLE;
            next_elapsed = '0;
          end
        end
        ST_MARK, ST_SPACE: begin
          if (!trig) begin
            next_state = ST_IDLE;
            next_elapsed = '0;
            next_contact = 1'b0;
          end else if (expired) begin
            next_state = (state == ST_MARK) ? ST_SPACE : ST_MARK;
            next_elapsed = '0;
            next_contact = (state == ST_SPACE);
          end else begin
            next_elapsed = bumped;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_elapsed = '0;
          next_contact = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      ELAPSED_TIME <= '0;
      SWITCH_CONTACT <= 1'b0;
      restore_cnt <= RESTORE_WAIT;
    end else begin
      state <= next_state;
      ELAPSED_TIME <= next_elapsed;
      SWITCH_CONTACT <= next_contact;
      restore_cnt <= next_restore;
    end
  end

  // Retained copy follows the live state once restore is over
  always_comb begin
    wr_en = RETENTIVE_ACTIVE && (restore_cnt == RESTORE_DONE);
    wr_word.valid = 1'b1;
    wr_word.state = state;
    wr_word.elapsed = ELAPSED_TIME;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  chk_clear_forces_off: assert property (
    (restore_cnt == RESTORE_DONE && clr) |=> !SWITCH_CONTACT && ELAPSED_TIME == '0 && state == ST_IDLE)
    else $error("clear did not zero time and open contact");

  chk_clear_beats_trigger: assert property (
    (restore_cnt == RESTORE_DONE && clr && trig)[*2] |-> !SWITCH_CONTACT)
    else $error("contact closed while clear asserted");

  chk_hold_freezes_time: assert property (
    (live && hold && !expired && (state == ST_PULSE || (trig && (state == ST_MARK || state == ST_SPACE))))
    |=> $stable(ELAPSED_TIME))
    else $error("elapsed time moved while held");

  chk_pulse_kept_on: assert property (
    (live && state == ST_PULSE && !expired) |=> SWITCH_CONTACT && state == ST_PULSE)
    else $error("pulse cut short before setpoint");

  chk_pulse_ends_on_time: assert property (
    (live && state == ST_PULSE && expired) |=> !SWITCH_CONTACT ##1 (!SWITCH_CONTACT || !$past(trig)))
    else $error("pulse did not end at setpoint");

  chk_restart_after_clear: assert property (
    (live && state == ST_IDLE && trig && mode == MODE_PULSE) |=> state == ST_PULSE && SWITCH_CONTACT)
    else $error("held trigger did not restart pulse");

  chk_mark_to_space: assert property (
    (live && trig && state == ST_MARK && expired) |=> state == ST_SPACE && !SWITCH_CONTACT && ELAPSED_TIME == '0)
    else $error("mark phase did not hand over to space");

  chk_sym_phases_equal: assert property (
    (mode == MODE_FLASH_SYM) |=> OFF_PHASE_TIME == ON_PHASE_TIME)
    else $error("symmetric flashing phases differ");

  chk_flash_stops: assert property (
    (live && !trig && (state == ST_MARK || state == ST_SPACE)) |=> state == ST_IDLE && !SWITCH_CONTACT)
    else $error("flashing continued after trigger dropped");

  chk_stop_keeps_time: assert property (
    (restore_cnt == RESTORE_DONE && !clr && !RUN_MODE && RETENTIVE_ACTIVE) |=> $stable(ELAPSED_TIME))
    else $error("retentive time changed in stop");

  chk_skip_keeps_time: assert property (
    (live && SECTION_SKIPPED && state == ST_PULSE && tick && !hold && !expired)
    |=> ELAPSED_TIME != $past(ELAPSED_TIME))
    else $error("timing stopped while section skipped");

  chk_setpoint_clamp: assert property (
    (base == BASE_SEC && FIRST_TIME_SETPOINT > SP_MAX_SEC) |-> sp_on == SP_MAX_SEC)
    else $error("setpoint not saturated");

  chk_retain_subset: assert property (
    RETENTIVE_ACTIVE |-> RANK != NO_RANK && RANK <= $past(RETAIN_COUNT))
    else $error("non-retentive instance marked retentive");

  chk_space_to_mark: assert property (
    (live && trig && state == ST_SPACE && expired) |=> state == ST_MARK && SWITCH_CONTACT && ELAPSED_TIME == '0)
    else $error("space phase did not hand over to mark");

  chk_flash_clear_off: assert property (
    (restore_cnt == RESTORE_DONE && clr && (state == ST_MARK || state == ST_SPACE))
    |=> state == ST_IDLE && !SWITCH_CONTACT && ELAPSED_TIME == '0)
    else $error("clear did not stop flashing");

  chk_hold_keeps_phase: assert property (
    (live && hold && trig && !expired && (state == ST_MARK || state == ST_SPACE))
    |=> $stable(state) && $stable(SWITCH_CONTACT))
    else $error("flash phase changed while held");

  chk_flash_starts_mark: assert property (
    (live && state == ST_IDLE && trig && is_flash) |=> state == ST_MARK && SWITCH_CONTACT)
    else $error("flashing did not start with mark phase");

  chk_other_mode_pulse: assert property (
    (live && state == ST_IDLE && trig && !is_flash) |=> state == ST_PULSE && SWITCH_CONTACT)
    else $error("non-flash mode did not start a pulse");

  chk_done_stays_off: assert property (
    (live && state == ST_DONE) |=> !SWITCH_CONTACT)
    else $error("contact closed after pulse end");

  chk_no_retrigger: assert property (
    (live && state == ST_DONE && trig) |=> state == ST_DONE)
    else $error("held trigger fired a second pulse");

  chk_stop_opens_contact: assert property (
    (restore_cnt == RESTORE_DONE && !clr && !RUN_MODE) |=> !SWITCH_CONTACT)
    else $error("contact closed in stop");

  chk_restore_reload: assert property (
    (restore_cnt == RESTORE_LOAD && RETENTIVE_ACTIVE && saved.valid)
    |=> state == $past(saved.state) && ELAPSED_TIME == $past(saved.elapsed))
    else $error("retained time not reloaded after restart");

  chk_step_adds_one: assert property (
    (live && state == ST_PULSE && tick && !hold && !expired) |=> ELAPSED_TIME == $past(ELAPSED_TIME) + 16'h0001)
    else $error("elapsed time did not advance by one step");

  chk_clock_range_clamp: assert property (
    (base != BASE_SEC && FIRST_TIME_SETPOINT > SP_MAX_CLOCK) |=> ON_PHASE_TIME == SP_MAX_CLOCK)
    else $error("clock range setpoint not saturated");
endmodule // pulse_flash_timing_relay

// >>> dv/coil_model.sv
`timescale 1ns/1ps
module coil_model (
  input wire logic clk,
  input wire logic skip,
  input wire logic [2:0] req,
  output logic [2:0] coil
);
  logic [2:0] last;
  // A skipped section leaves its coils at their last values
  always_ff @(posedge clk) begin
    if (!skip) begin
      last <= req;
    end
  end
  assign coil = skip ? last : req;
endmodule // coil_model

// >>> dv/pulse_flash_timing_relay_tb.sv
`timescale 1ns/1ps
module pulse_flash_timing_relay_tb import relay_timer_pkg::*; ;
  localparam int SC = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic run = 1'b1;
  logic skip = 1'b0;
  logic [2:0] req = 3'h0;
  logic [2:0] coil;
  logic [1:0] mode = 2'h0;
  logic [1:0] base = 2'h0;
  logic [TW-1:0] sp1 = 16'h0005;
  logic [TW-1:0] sp2 = 16'h0005;
  logic [2:0] rcnt = 3'h0;
  logic sw;
  logic ret;
  logic [TW-1:0] el;
  logic [TW-1:0] onp;
  logic [TW-1:0] offp;
  int err_count = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  // Coil order in req is clear, hold, trigger
  coil_model i_coil (.clk(clk), .skip(skip), .req(req), .coil(coil));

  pulse_flash_timing_relay #(.INSTANCE_NUM(7), .STEP_CYCLES(SC)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .RUN_MODE(run), .SECTION_SKIPPED(skip),
    .TRIGGER_COIL_INPUT(coil[0]), .HOLD_COIL_INPUT(coil[1]), .CLEAR_COIL_INPUT(coil[2]),
    .RELAY_MODE(mode), .TIME_BASE(base), .FIRST_TIME_SETPOINT(sp1), .SECOND_TIME_SETPOINT(sp2),
    .RETAIN_COUNT(rcnt), .SWITCH_CONTACT(sw), .ELAPSED_TIME(el), .ON_PHASE_TIME(onp),
    .OFF_PHASE_TIME(offp), .RETENTIVE_ACTIVE(ret)
  );

  task automatic chk(input logic [TW-1:0] seen, input logic [TW-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic inr(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Free-running steps make the first step partial, hence the count windows
  task automatic pulse(input int tl, input int ha, input int hl, output int n);
    logic [TW-1:0] e0;
    n = 0;
    for (int i = 0; i < 160; i++) begin
      @(negedge clk);
      if (sw === 1'b1) begin
        n++;
      end
      if (i == ha + 2) begin
        e0 = el;
      end
      if (hl > 0 && i == ha + hl) begin
        chk(el, e0);
      end
      req = {1'b0, i >= ha && i < ha + hl, i < tl};
    end
    // Let an edge pass so req is not driven twice in one time step
    cyc(1);
    req = 3'h0;
    cyc(2);
  endtask

  task automatic t_sat;
    sp1 = 16'hFFFF;
    cyc(2);
    chk(onp, SP_MAX_SEC);
    base = BASE_MIN_SEC;
    cyc(2);
    chk(onp, SP_MAX_CLOCK);
    base = BASE_HR_MIN;
    cyc(2);
    chk(onp, SP_MAX_CLOCK);
    base = BASE_SEC;
    sp1 = 16'h0005;
    cyc(2);
    $display("test saturation done");
  endtask

  task automatic t_pulse;
    int n;
    pulse(1, 0, 0, n);
    chk(inr(n, 16, 22), 1'b1);
    pulse(160, 0, 0, n);
    chk(inr(n, 16, 22), 1'b1);
    pulse(1, 6, 20, n);
    chk(inr(n, 33, 44), 1'b1);
    // Spare mode code behaves as a single pulse
    mode = 2'h3;
    pulse(1, 0, 0, n);
    chk(inr(n, 16, 22), 1'b1);
    mode = MODE_PULSE;
    $display("test pulse done");
  endtask

  task automatic t_clear;
    req = 3'h1;
    cyc(6);
    req = 3'h7;
    cyc(2);
    chk(sw, 1'b0);
    chk(el, 16'h0);
    req = 3'h1;
    cyc(1);
    chk(sw, 1'b1);
    chk(el, 16'h0);
    req = 3'h0;
    cyc(30);
    chk(sw, 1'b0);
    $display("test clear done");
  endtask

  task automatic t_flash(input logic [1:0] m, input int a, input int b);
    int r[4];
    int k;
    int eb;
    logic s0;
    logic [TW-1:0] e0;
    mode = m;
    sp1 = 16'(a);
    sp2 = 16'(b);
    eb = (m == MODE_FLASH_SYM) ? a : b;
    r = '{0, 0, 0, 0};
    k = 0;
    s0 = 1'b1;
    req = 3'h1;
    cyc(1);
    for (int i = 0; i < 400 && k < 4; i++) begin
      @(negedge clk);
      if (sw !== s0) begin
        k++;
        s0 = sw;
      end else begin
        r[k]++;
      end
    end
    chk(onp, 16'(a));
    chk(offp, 16'(eb));
    chk(inr(r[2], 4 * a - 3, 4 * a + 1), 1'b1);
    chk(inr(r[1], 4 * eb - 3, 4 * eb + 1), 1'b1);
    req = 3'h3;
    cyc(2);
    s0 = sw;
    e0 = el;
    cyc(20);
    chk(sw, s0);
    chk(el, e0);
    req = 3'h7;
    cyc(2);
    chk(sw, 1'b0);
    chk(el, 16'h0);
    req = 3'h1;
    cyc(4);
    req = 3'h0;
    cyc(2);
    chk(sw, 1'b0);
    mode = MODE_PULSE;
    sp1 = 16'h0005;
    cyc(4);
    $display("test flash done");
  endtask

  task automatic t_retain;
    logic [TW-1:0] e0;
    chk(ret, 1'b0);
    rcnt = 3'h1;
    cyc(2);
    chk(ret, 1'b1);
    sp1 = 16'h0030;
    req = 3'h1;
    cyc(30);
    req = 3'h3;
    cyc(3);
    e0 = el;
    run = 1'b0;
    cyc(3);
    chk(sw, 1'b0);
    chk(el, e0);
    run = 1'b1;
    cyc(3);
    // Power loss: the trigger stays as it was, as a restart requires
    arst_n = 1'b0;
    cyc(2);
    chk(sw, 1'b0);
    arst_n = 1'b1;
    cyc(3);
    chk(el, e0);
    chk(sw, 1'b1);
    req = 3'h1;
    cyc(1);
    skip = 1'b1;
    req = 3'h0;
    e0 = el;
    cyc(12);
    chk(inr(int'(el) - int'(e0), 2, 4), 1'b1);
    chk(sw, 1'b1);
    skip = 1'b0;
    cyc(250);
    rcnt = 3'h0;
    $display("test retain done");
  endtask

  initial begin
    cyc(10);
    arst_n = 1'b1;
    cyc(3);
    t_sat;
    t_pulse;
    t_clear;
    t_flash(MODE_FLASH_SYM, 3, 9);
    t_flash(MODE_FLASH_ASYM, 3, 6);
    t_retain;
    wrap_up;
  end

  initial begin
    #400000;
    err_count++;
    wrap_up;
  end
endmodule // pulse_flash_timing_relay_tb
